// ### verilog/lbtest_pkg.sv
// Purpose: Shared constants and types for the loopback and XAUI test block.
// Assumes: One XAUI lane carries one 10-bit code group per clock, bit 0 first.
// Notes:   Register fields are packed structs; bit 0 of a word is the last
//          field of its struct.
`default_nettype none

package lbtest_pkg;

  // --------------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------------
  localparam int LANES = 4;
  localparam int LANE_W = 10;
  localparam int LINE_W = 16;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 8;

  // --------------------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_SYS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_NET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ANA = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TST = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CNT0 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STEP = 8'h04;

  // --------------------------------------------------------------------------
  // Fixed words and patterns
  // --------------------------------------------------------------------------
  localparam logic [LINE_W-1:0] LINE_ZERO = 16'h0000;
  localparam logic [LINE_W-1:0] LINE_ONES = 16'hFFFF;
  localparam logic [LINE_W-1:0] LINE_00FF = 16'h00FF;
  localparam logic [LANE_W-1:0] SYM_ZERO = 10'h000;
  localparam logic [LANE_W-1:0] SYM_IDLE = 10'h0FA;
  localparam logic [LANE_W-1:0] SYM_CLK = 10'h155;
  localparam logic [LANE_W-1:0] JIT_HF = 10'h155;
  localparam logic [LANE_W-1:0] JIT_LF = 10'h01F;
  localparam logic [LANE_W-1:0] JIT_MF_A = 10'h35F;
  localparam logic [LANE_W-1:0] JIT_MF_B = 10'h0A0;
  localparam logic [1:0] JSEL_HF = 2'h0;
  localparam logic [1:0] JSEL_LF = 2'h1;
  localparam logic [1:0] JSEL_MF = 2'h2;
  localparam logic [6:0] PRBS_SEED = 7'h7F;
  localparam logic [6:0] PRBS_ZERO = 7'h00;
  localparam logic [7:0] CR_IFG = 8'h0C;
  localparam logic [7:0] CR_LAST = 8'h3F;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef logic [LANES-1:0][LANE_W-1:0] lanes_t;

  typedef struct packed {
    logic xgxs_ovr;
    logic pcs_ovr;
    logic wis_ovr;
    logic pma_ovr;
    logic xgxs_en;
    logic pcs_en;
    logic wis_en;
    logic pma_en;
  } sys_ctrl_t;

  typedef struct packed {
    logic pma_ovr;
    logic xgxs_ovr;
    logic line_time;
    logic pma_en;
    logic xgxs_en;
  } net_ctrl_t;

  typedef struct packed {
    logic [3:0] data_sel;
    logic [3:0] clk_sel;
    logic [2:0] rsv;
    logic net_b;
    logic net_a;
    logic sys_c;
    logic sys_b;
    logic sys_a;
  } ana_ctrl_t;

  typedef struct packed {
    logic [1:0] jit_sel;
    logic jit_en;
    logic crpat_en;
    logic chk_en;
    logic gen_en;
  } test_ctrl_t;

  localparam sys_ctrl_t SYS_RST = '0;
  localparam net_ctrl_t NET_RST = 5'h18;
  localparam ana_ctrl_t ANA_RST = '0;
  localparam test_ctrl_t TST_RST = '0;

  typedef struct packed {
    sys_ctrl_t sys;
    net_ctrl_t net;
    ana_ctrl_t ana;
    test_ctrl_t tst;
    logic pma_ovr_eff;
    logic [6:0] lfsr;
    logic [LANES-1:0][6:0] hist;
    logic [LANES-1:0] err_flag;
    logic [LANES-1:0][CNT_W-1:0] err_cnt;
    logic [LANES-1:0] lk1;
    logic [LANES-1:0] lk2;
    logic [LANES-1:0] lk3;
    logic [LANES-1:0] lock;
    logic [7:0] cr_cnt;
    logic jit_ph;
    lanes_t xaui_out;
    logic [LINE_W-1:0] line_out;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

endpackage

`default_nettype wire

// ### verilog/loopback_test_ctrl.sv
// Purpose: Loopback routing and XAUI test patterns of the 10G path.
// Assumes: APB slave without wait states; lanes bit 0 first.
// Notes:   All state is one registered struct; data outputs are registered.
// Function
// - All features except analog network loopback work only on the 10G path, never in 1G mode; line_timing_force_enable follows its bit in 1G mode too.
// - System loopback returns XAUI input lanes on the XAUI output.
// - Separate system loopback enables for PMA, WIS, PCS and XGXS.
// - Line output in system loopback depends on layer and override bit.
// - Each system loopback has its own data override bit.
// - All system loopback override bits reset to zero.
// - PMA override is set before enabling; changes ignored while active.
// - Analog system loopback sends a chosen lane to lane 2 output.
// - Network loopback returns received line data to the line output.
// - Several loopbacks at once are not blocked; result undefined.
// - XGXS network enable bit; PMA network needs enable and timing bit.
// - Network overrides reset to one; cleared gives zeros or idle codes.
// - Analog network loopback also works in 1G mode.
// - PMA network loopback needs line timing; force bit turns it on.
// - PRBS7 generator drives all four XAUI lanes at once.
// - Per-lane PRBS7 error flags latch and clear only on read.
// - Per-lane 8-bit error counters saturate and clear on read.
// - Any unlocked input lane makes all checkers report errors.
// - CRPAT sends identical packets separated by minimum gap.
// - Jitter generator sends high, low or mixed frequency patterns.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module loopback_test_ctrl
  import lbtest_pkg::*;
#(
  parameter logic [6:0] SEED = PRBS_SEED
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rate_1g_mode,
  input wire logic [LANES-1:0] xaui_lane_locked,
  input wire lanes_t xaui_rx_lanes,
  input wire lanes_t rx_path_lanes,
  input wire logic [LINE_W-1:0] tx_path_word,
  input wire logic [LINE_W-1:0] line_rx_word,
  output lanes_t xaui_lane_output,
  output logic [LINE_W-1:0] line_serial_output,
  output logic line_timing_force_enable
);

  if (SEED == PRBS_ZERO) begin : g_seed_check
    $error("PRBS7 seed must be non-zero.");
  end

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] cnt_addr(input int i);
    return OFS_CNT0 + OFS_STEP * ADDR_W'(i);
  endfunction

  // Returns {hit, data} for the register at address a.
  function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] a,
                                          input state_t s);
    logic [32:0] r;
    r = '0;
    unique case (a)
      OFS_SYS: r = {1'b1, 24'h0, s.sys};
      OFS_NET: r = {1'b1, 27'h0, s.net};
      OFS_ANA: r = {1'b1, 16'h0, s.ana};
      OFS_TST: r = {1'b1, 26'h0, s.tst};
      OFS_FLAG: r = {1'b1, 24'h0, s.lock, s.err_flag};
      default: begin
        for (int i = 0; i < LANES; i++) begin
          if (a == cnt_addr(i)) begin
            r = {1'b1, 24'h0, s.err_cnt[i]};
          end
        end
      end
    endcase
    return r;
  endfunction

  // Advances the x^7+x^6+1 generator by one lane word.
  function automatic logic [LANE_W+6:0] prbs_step(input logic [6:0] s);
    logic [6:0] r;
    logic [LANE_W-1:0] w;
    logic b;
    r = s;
    w = '0;
    b = 1'b0;
    for (int k = 0; k < LANE_W; k++) begin
      b = r[6] ^ r[5];
      w[k] = b;
      r = {r[5:0], b};
    end
    return {w, r};
  endfunction

  // Self-synchronising check: each bit is predicted from the 7 before it.
  function automatic logic [7:0] prbs_chk(input logic [6:0] h,
                                         input logic [LANE_W-1:0] w);
    logic [6:0] r;
    logic e;
    r = h;
    e = 1'b0;
    for (int k = 0; k < LANE_W; k++) begin
      e = e | (w[k] != (r[6] ^ r[5]));
      r = {r[5:0], w[k]};
    end
    return {e, r};
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  state_t q;
  state_t d;
  logic active;
  logic sys_any;
  logic pma_net;
  logic ana_sys;
  logic ana_net;
  logic pat_any;
  logic rd_acc;

  assign active = !rate_1g_mode;
  assign sys_any = q.sys.pma_en | q.sys.wis_en | q.sys.pcs_en | q.sys.xgxs_en;
  assign pma_net = q.net.pma_en & q.net.line_time;
  assign ana_sys = q.ana.sys_a & q.ana.sys_b & q.ana.sys_c;
  assign ana_net = q.ana.net_a & q.ana.net_b;
  assign pat_any = q.tst.gen_en | q.tst.crpat_en | q.tst.jit_en;
  assign rd_acc = psel & penable & !pwrite;

  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign pready = penable;
  assign xaui_lane_output = q.xaui_out;
  assign line_serial_output = q.line_out;
  assign line_timing_force_enable = q.net.line_time;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [32:0] rv;
    logic [LANE_W+6:0] g;
    logic [7:0] c;
    logic err;
    logic [CNT_W-1:0] base;
    lanes_t xo;
    logic [LINE_W-1:0] lo;
    logic [LANE_W-1:0] jw;
    logic [LANE_W-1:0] cw;
    rv = reg_read(paddr, q);
    g = prbs_step(q.lfsr);
    c = '0;
    err = 1'b0;
    base = '0;
    xo = rx_path_lanes;
    lo = tx_path_word;
    jw = JIT_HF;
    cw = SYM_IDLE;
    d = q;

    // Read data is caught in the setup phase, so a read clears only what
    // it actually reported and an error in between is never lost.
    if (psel && !penable) begin
      d.prdata = rv[31:0];
      d.pslverr = !rv[32];
    end
    if (psel && penable && pwrite && !q.pslverr) begin
      case (paddr)
        OFS_SYS: d.sys = sys_ctrl_t'(pwdata[$bits(sys_ctrl_t)-1:0]);
        OFS_NET: d.net = net_ctrl_t'(pwdata[$bits(net_ctrl_t)-1:0]);
        OFS_ANA: begin
          d.ana = ana_ctrl_t'(pwdata[$bits(ana_ctrl_t)-1:0]);
          d.ana.rsv = '0;
        end
        OFS_TST: d.tst = test_ctrl_t'(pwdata[$bits(test_ctrl_t)-1:0]);
        default: ;
      endcase
    end

    // The PMA override is frozen while its loopback runs.
    if (!q.sys.pma_en) begin
      d.pma_ovr_eff = q.sys.pma_ovr;
    end

    // Lock inputs: three stages, a change counts once stages 2 and 3 agree.
    d.lk1 = xaui_lane_locked;
    d.lk2 = q.lk1;
    d.lk3 = q.lk2;
    d.lock = (q.lk2 & q.lk3) | (q.lock & (q.lk2 ^ q.lk3));

    // PRBS7 generator; the seed reload keeps it out of the all-zero lock-up.
    if (q.tst.gen_en && active && g[6:0] != PRBS_ZERO) begin
      d.lfsr = g[6:0];
    end else begin
      d.lfsr = SEED;
    end

    // Checkers, sticky flags and saturating counters.
    for (int i = 0; i < LANES; i++) begin
      c = prbs_chk(q.hist[i], xaui_rx_lanes[i]);
      d.hist[i] = c[6:0];
      err = q.tst.chk_en && active && (c[7] || !(&q.lock));
      d.err_flag[i] = (q.err_flag[i] & !(rd_acc && paddr == OFS_FLAG &&
                       q.prdata[i])) | err;
      base = q.err_cnt[i];
      if (rd_acc && paddr == cnt_addr(i)) begin
        base = q.err_cnt[i] - q.prdata[CNT_W-1:0];
      end
      if (err && base != CNT_MAX) begin
        base = base + CNT_ONE;
      end
      d.err_cnt[i] = base;
    end

    // CRPAT: the same packet every period after a minimum idle gap.
    if (q.tst.crpat_en && active) begin
      d.cr_cnt = (q.cr_cnt == CR_LAST) ? '0 : q.cr_cnt + 8'h01;
    end else begin
      d.cr_cnt = '0;
    end
    if (q.cr_cnt >= CR_IFG) begin
      cw = {~q.cr_cnt[4:0], q.cr_cnt[4:0]};
    end
    d.jit_ph = q.tst.jit_en ? !q.jit_ph : 1'b0;
    unique case (q.tst.jit_sel)
      JSEL_LF: jw = JIT_LF;
      JSEL_MF: jw = q.jit_ph ? JIT_MF_B : JIT_MF_A;
      default: jw = JIT_HF;
    endcase

    // Output routing; later assignments take precedence.
    if (ana_net) begin
      lo = line_rx_word;
    end
    if (active && q.net.xgxs_en) begin
      lo = line_rx_word;
      xo = q.net.xgxs_ovr ? rx_path_lanes : {LANES{SYM_ZERO}};
    end
    if (active && pma_net) begin
      lo = line_rx_word;
      xo = q.net.pma_ovr ? rx_path_lanes : {LANES{SYM_IDLE}};
    end
    if (active && sys_any) begin
      xo = xaui_rx_lanes;
      if (q.sys.pma_en) begin
        lo = q.pma_ovr_eff ? LINE_ZERO : tx_path_word;
      end else if (q.sys.wis_en) begin
        lo = q.sys.wis_ovr ? tx_path_word : LINE_00FF;
      end else if (q.sys.pcs_en) begin
        lo = q.sys.pcs_ovr ? tx_path_word : LINE_00FF;
      end else begin
        lo = q.sys.xgxs_ovr ? tx_path_word : LINE_ONES;
      end
    end
    if (active && ana_sys) begin
      for (int i = 0; i < LANES; i++) begin
        if (q.ana.clk_sel[i]) begin
          xo[2] = SYM_CLK;
        end
        if (q.ana.data_sel[i]) begin
          xo[2] = xaui_rx_lanes[i];
        end
      end
    end
    if (active && q.tst.jit_en) begin
      xo = {LANES{jw}};
    end
    if (active && q.tst.crpat_en) begin
      xo = {LANES{cw}};
    end
    if (active && q.tst.gen_en) begin
      xo = {LANES{g[LANE_W+6:7]}};
    end
    d.xaui_out = xo;
    d.line_out = lo;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.sys <= SYS_RST;
      q.net <= NET_RST;
      q.ana <= ANA_RST;
      q.tst <= TST_RST;
      q.lfsr <= SEED;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic quiet_x;
  assign quiet_x = !pat_any && !ana_sys;

  AST_SYS_RETURN: assert property (
    (active && sys_any && quiet_x) |=>
      (xaui_lane_output == $past(xaui_rx_lanes)))
    else $error("System loopback did not return XAUI input.");

  AST_PMA_SYS_LINE: assert property (
    (active && q.sys.pma_en) |=>
      (line_serial_output ==
       ($past(q.pma_ovr_eff) ? LINE_ZERO : $past(tx_path_word))))
    else $error("PMA system loopback line word wrong.");

  AST_XGXS_SYS_LINE: assert property (
    (active && q.sys == 8'h08) |=> (line_serial_output == LINE_ONES))
    else $error("XGXS system loopback line word not all ones.");

  AST_OVR_HOLD: assert property (
    (q.sys.pma_en && $past(q.sys.pma_en)) |-> $stable(q.pma_ovr_eff))
    else $error("PMA override changed while loopback active.");

  AST_NET_LOOP: assert property (
    (active && q.net.xgxs_en && !sys_any) |=>
      (line_serial_output == $past(line_rx_word)))
    else $error("Network loopback did not return received data.");

  AST_NET_ZERO: assert property (
    (active && q.net.xgxs_en && !q.net.xgxs_ovr && !pma_net && !sys_any &&
     quiet_x) |=>
      (xaui_lane_output == '0))
    else $error("Cleared XGXS network override did not send zeros.");

  AST_ANA_NET_1G: assert property (
    (rate_1g_mode && ana_net) |=>
      (line_serial_output == $past(line_rx_word)))
    else $error("Analog network loopback lost in 1G mode.");

  AST_1G_OFF: assert property (
    (rate_1g_mode && !ana_net) |=>
      (line_serial_output == $past(tx_path_word)) &&
      (xaui_lane_output == $past(rx_path_lanes)))
    else $error("Test feature active in 1G mode.");

  AST_PRBS_LANES: assert property (
    (active && q.tst.gen_en) |=>
      (xaui_lane_output[0] == xaui_lane_output[3]) && (q.lfsr != PRBS_ZERO))
    else $error("PRBS7 lanes differ or generator stuck at zero.");

  AST_FLAG_STICKY: assert property (
    (q.err_flag[0] && !(rd_acc && paddr == OFS_FLAG)) |=> q.err_flag[0])
    else $error("Error flag cleared without a read.");

  AST_CNT_SAT: assert property (
    (q.err_cnt[1] == CNT_MAX && !(rd_acc && paddr == cnt_addr(1))) |=>
      (q.err_cnt[1] == CNT_MAX))
    else $error("Error counter wrapped or dropped.");

  AST_UNLOCK_ERR: assert property (
    (active && q.tst.chk_en && !(&q.lock)) |=> (&q.err_flag))
    else $error("Unlocked lane did not flag all lanes.");

  AST_JIT_LF: assert property (
    (active && q.tst.jit_en && q.tst.jit_sel == JSEL_LF && !q.tst.gen_en &&
     !q.tst.crpat_en) |=> (xaui_lane_output[1] == JIT_LF))
    else $error("Low frequency jitter pattern wrong.");

  COV_SYS: cover property (active && sys_any ##1 sys_any);
  COV_NET: cover property (active && pma_net ##1 pma_net);
  COV_FLAG: cover property ($rose(q.err_flag[2]));
  COV_SAT: cover property (q.err_cnt[0] == CNT_MAX);

endmodule // loopback_test_ctrl

`default_nettype wire

// ### verification/mac_lane_model.sv
// Purpose: Far-end MAC model that drives the four XAUI input lanes.
// Assumes: One 10-bit word per lane per clock, bit 0 sent first.
// Notes:   Sends either held data or a PRBS7 stream with bit flips on demand.
`timescale 1ns/1ns
`default_nettype none

module mac_lane_model
  import lbtest_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic prbs_mode,
  input wire logic [LANES-1:0] flip,
  input wire lanes_t data_lanes,
  output var lanes_t lanes
);
  // --------------------------------------------------------------------------
  // Pattern source
  // --------------------------------------------------------------------------
  logic [6:0] h_q;
  logic [6:0] h_d;
  logic [LANE_W-1:0] w;

  // Each bit is the sum of the bits sent six and seven places earlier.
  always_comb begin
    h_d = h_q;
    for (int i = 0; i < LANE_W; i++) begin
      w[i] = h_d[5] ^ h_d[6];
      h_d = {h_d[5:0], w[i]};
    end
  end

  // A flip spoils one bit of one word; the history stays clean, so the
  // checker sees exactly one bad word per flip.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_q <= 7'h01;
      lanes <= '0;
    end else begin
      h_q <= h_d;
      for (int l = 0; l < LANES; l++) begin
        lanes[l] <= prbs_mode ? (w ^ {9'h000, flip[l]}) : data_lanes[l];
      end
    end
  end
endmodule // mac_lane_model

`default_nettype wire

// ### verification/tb.sv
// Purpose: Self-checking bench for the loopback and XAUI test block.
// Assumes: APB access phase of one cycle; outputs lag inputs by one cycle.
// Notes:   Expected results go to a queue that a watcher drains.
`timescale 1ns/1ns
`default_nettype none

module tb;
  import lbtest_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rate_1g = 1'b0;
  logic [3:0] lock = 4'hF;
  lanes_t xin;
  lanes_t rx_path = '0;
  logic [15:0] tx_word = 16'h0;
  logic [15:0] rx_word = 16'h0;
  lanes_t xout;
  logic [15:0] lout;
  logic lt_en;
  logic prbs_mode = 1'b0;
  logic [3:0] flip = 4'h0;
  lanes_t mac_data = '0;
  integer seed = 32'hacb208db;
  int errors = 0;
  int comparisons = 0;
  int bad;
  int idle;
  logic [41:0] q[$];
  logic [9:0] w0;
  logic [9:0] w1;
  logic [159:0] bits;
  logic [9:0] cr[128];

  always #5 pclk = ~pclk;

  loopback_test_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rate_1g_mode(rate_1g), .xaui_lane_locked(lock), .xaui_rx_lanes(xin),
    .rx_path_lanes(rx_path), .tx_path_word(tx_word),
    .line_rx_word(rx_word), .xaui_lane_output(xout),
    .line_serial_output(lout), .line_timing_force_enable(lt_en));

  mac_lane_model mac (.pclk(pclk), .presetn(presetn), .prbs_mode(prbs_mode),
    .flip(flip), .data_lanes(mac_data), .lanes(xin));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input string name, input logic [39:0] seen,
                       input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic chk, input logic [32:0] exp);
    int n = 0;
    if (chk) begin
      q.push_back({2'd0, 7'h00, exp});
    end
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) begin
      errors++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'($random(seed)), 1'b1, e);
  endtask

  // Outputs are registered, so three edges cover any setting just written.
  task automatic expect_out(input logic [1:0] kind, input logic [39:0] v);
    repeat (3) @(posedge pclk);
    q.push_back({kind, v});
  endtask

  task automatic shuffle();
    @(posedge pclk);
    mac_data <= 40'({$random(seed), $random(seed)});
    rx_path <= 40'({$random(seed), $random(seed)});
    tx_word <= 16'($random(seed));
    rx_word <= 16'($random(seed));
    @(negedge pclk);
  endtask

  function automatic logic [39:0] sys_line(int i, int o);
    if (i == 0) begin
      return {24'h0, o ? LINE_ZERO : tx_word};
    end
    return {24'h0, o ? tx_word : (i == 3 ? LINE_ONES : LINE_00FF)};
  endfunction

  // --------------------------------------------------------------------------
  // Watcher
  // --------------------------------------------------------------------------
  always @(negedge pclk) begin
    if (q.size() > 0) begin
      if (q[0][41:40] == 2'd0 && psel && penable && !pwrite) begin
        check("apb_read", {7'h00, pslverr, prdata}, q[0][39:0]);
        void'(q.pop_front());
      end else if (q[0][41:40] != 2'd0) begin
        case (q[0][41:40])
          2'd1: check("xaui_out", xout, q[0][39:0]);
          2'd2: check("line_out", {24'h0, lout}, q[0][39:0]);
          default: check("xaui_lane2", {30'h0, xout[2]}, q[0][39:0]);
        endcase
        void'(q.pop_front());
      end
    end
  end

  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    conclude();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_SYS, 33'h0);
    rd(OFS_NET, 33'h18);
    rd(OFS_ANA, 33'h0);
    rd(OFS_TST, 33'h0);
    rd(8'h40, 33'h100000000);
    shuffle();
    expect_out(2'd1, rx_path);
    for (int i = 0; i < 4; i++) begin
      for (int o = 0; o < 2; o++) begin
        wr(OFS_SYS, 32'(o << (4 + i)));
        wr(OFS_SYS, 32'((o << (4 + i)) | (1 << i)));
        expect_out(2'd1, mac_data);
        expect_out(2'd2, sys_line(i, o));
        if (i == 0) begin
          wr(OFS_SYS, 32'(((1 - o) << 4) | 1));
          expect_out(2'd2, sys_line(i, o));
        end
      end
    end
    wr(OFS_SYS, 32'h0);
    @(posedge pclk);
    rate_1g <= 1'b1;
    wr(OFS_SYS, 32'h08);
    expect_out(2'd1, rx_path);
    wr(OFS_SYS, 32'h0);
    wr(OFS_NET, 32'h0);
    wr(OFS_ANA, 32'h08);
    wr(OFS_ANA, 32'h18);
    expect_out(2'd2, {24'h0, rx_word});
    wr(OFS_ANA, 32'h0);
    @(posedge pclk);
    rate_1g <= 1'b0;
    wr(OFS_NET, 32'h19);
    expect_out(2'd1, rx_path);
    expect_out(2'd2, {24'h0, rx_word});
    wr(OFS_NET, 32'h11);
    expect_out(2'd1, 40'h0);
    wr(OFS_NET, 32'h1A);
    expect_out(2'd2, {24'h0, tx_word});
    wr(OFS_NET, 32'h0E);
    expect_out(2'd1, {4{SYM_IDLE}});
    expect_out(2'd2, {24'h0, rx_word});
    check("line_timing", {39'h0, lt_en}, 40'h1);
    wr(OFS_NET, 32'h18);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_ANA, 32'(16'h1000 << k) | 32'h3);
      expect_out(2'd3, {30'h0, rx_path[2]});
      wr(OFS_ANA, 32'(16'h1000 << k) | 32'h7);
      expect_out(2'd3, {30'h0, mac_data[k]});
    end
    wr(OFS_ANA, 32'h0107);
    expect_out(2'd3, {30'h0, SYM_CLK});
    wr(OFS_ANA, 32'h0);
    wr(OFS_TST, 32'h08);
    expect_out(2'd1, {4{JIT_HF}});
    wr(OFS_TST, 32'h18);
    expect_out(2'd1, {4{JIT_LF}});
    wr(OFS_TST, 32'h28);
    repeat (3) @(negedge pclk);
    w0 = xout[0];
    @(negedge pclk);
    w1 = xout[0];
    check("jit_mixed", {20'h0, w0, w1}, (w0 === JIT_MF_A) ?
          {20'h0, JIT_MF_A, JIT_MF_B} : {20'h0, JIT_MF_B, JIT_MF_A});
    wr(OFS_TST, 32'h04);
    bad = 0;
    idle = 0;
    // The word after the enabling edge still carries the previous pattern.
    @(negedge pclk);
    for (int n = 0; n < 128; n++) begin
      @(negedge pclk);
      cr[n] = xout[0];
    end
    for (int n = 0; n < 64; n++) begin
      bad += (cr[n] !== cr[n + 64]);
      idle += (cr[n] === SYM_IDLE);
    end
    check("crpat_period", 40'(bad), 40'h0);
    check("crpat_gap", 40'(idle), {32'h0, CR_IFG});
    wr(OFS_TST, 32'h01);
    repeat (3) @(negedge pclk);
    bad = 0;
    for (int n = 0; n < 16; n++) begin
      @(negedge pclk);
      bits[10 * n +: 10] = xout[0];
      bad += (xout !== {4{xout[0]}});
    end
    for (int n = 7; n < 160; n++) begin
      bad += (bits[n] !== (bits[n - 6] ^ bits[n - 7]));
    end
    check("prbs_errors", 40'(bad), 40'h0);
    check("prbs_live", {39'h0, |bits}, 40'h1);
    @(posedge pclk);
    prbs_mode <= 1'b1;
    wr(OFS_TST, 32'h02);
    repeat (20) @(posedge pclk);
    for (int c = 0; c < 5; c++) begin
      apb(1'b0, OFS_FLAG + 8'(4 * c), 32'h0, 1'b0, 33'h0);
    end
    @(posedge pclk);
    flip <= 4'h2;
    @(posedge pclk);
    flip <= 4'h0;
    repeat (5) @(posedge pclk);
    rd(OFS_FLAG, 33'hF2);
    rd(OFS_FLAG, 33'hF0);
    rd(OFS_CNT0 + 8'h04, 33'h1);
    rd(OFS_CNT0 + 8'h04, 33'h0);
    rd(OFS_CNT0, 33'h0);
    // Confirm lock first, then drop one lane long enough to saturate.
    @(posedge pclk);
    lock <= 4'hE;
    repeat (300) @(posedge pclk);
    lock <= 4'hF;
    repeat (10) @(posedge pclk);
    rd(OFS_FLAG, 33'hFF);
    for (int l = 0; l < 4; l++) begin
      rd(OFS_CNT0 + 8'(4 * l), 33'hFF);
    end
    rd(OFS_CNT0 + 8'h0C, 33'h0);
    repeat (3) @(posedge pclk);
    conclude();
  end
endmodule // tb

`default_nettype wire
